// ### logic_step_flipflop.sv
`timescale 1ns/1ps
module logic_step_flipflop
    import logic_step_pkg::*;
#(
    parameter int TASK_2MS_COUNT = TASK_2MS_CYCLES,
    parameter int TASK_5MS_COUNT = TASK_5MS_CYCLES,
    parameter int TASK_10MS_COUNT = TASK_10MS_CYCLES,
    parameter int TASK_20MS_COUNT = TASK_20MS_CYCLES
)(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_reset_n,
    // Configuration
    input wire logic [1:0] i_task_cycle_select,
    input wire latch_mode_t i_latch_mode,
    input wire logic [SELECT_W-1:0] i_first_input_select,
    input wire logic [SELECT_W-1:0] i_second_input_select,
    // Drive internal sources
    input wire logic [STATUS_COUNT-1:0] i_status_output_assignment,
    input wire logic [STEP_COUNT-1:0] i_logic_step_results,
    input wire logic i_final_drive_command,
    input wire logic i_final_forward_command,
    input wire logic i_final_reverse_command,
    input wire logic i_accelerating_flag,
    input wire logic i_decelerating_flag,
    input wire logic i_anti_regeneration_flag,
    input wire logic i_alarm_factor_flag,
    // Terminal pins
    input wire logic [TERMINAL_COUNT-1:0] i_digital_terminals,
    input wire logic i_forward_run_terminal,
    input wire logic i_reverse_run_terminal,
    // Results
    output logic o_logic_step_result,
    output logic o_task_tick
);

    // Pin synchroniser
    logic [TERMINAL_COUNT+1:0] term_meta;
    logic [TERMINAL_COUNT+1:0] term_sync;
    logic [TERMINAL_COUNT+1:0] next_term_meta;
    logic [TERMINAL_COUNT+1:0] next_term_sync;
    logic [TERMINAL_COUNT-1:0] sync_terminals;
    logic sync_forward;
    logic sync_reverse;

    // Selected step inputs
    logic first_input;
    logic second_input;

    // Task cycle divider
    logic [TICK_CNT_W-1:0] tick_count;
    logic [TICK_CNT_W-1:0] next_tick_count;
    logic [TICK_CNT_W-1:0] reload_count;
    logic next_task_tick;

    // Latch
    logic next_result;

    function automatic logic [TICK_CNT_W-1:0] task_period(input logic [1:0] sel);
        int n;
        case (sel)
            TASK_SEL_2MS: n = TASK_2MS_COUNT;
            TASK_SEL_5MS: n = TASK_5MS_COUNT;
            TASK_SEL_10MS: n = TASK_10MS_COUNT;
            TASK_SEL_20MS: n = TASK_20MS_COUNT;
            default: n = TASK_2MS_COUNT;
        endcase
        return TICK_CNT_W'(n - 1);
    endfunction : task_period

    // Terminal pins are asynchronous to the task clock
    always_comb begin
        next_term_meta = {i_reverse_run_terminal, i_forward_run_terminal, i_digital_terminals};
        next_term_sync = term_meta;
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            term_meta <= '0;
            term_sync <= '0;
        end else begin
            term_meta <= next_term_meta;
            term_sync <= next_term_sync;
        end
    end

    // Only the second stage is read; the first may still be settling
    // Pins therefore reach the latch two cycles after internal sources
    assign sync_terminals = term_sync[TERMINAL_COUNT-1:0];
    assign sync_forward = term_sync[TERMINAL_COUNT];
    assign sync_reverse = term_sync[TERMINAL_COUNT+1];

    // Selectors register their pick, so a source reaches the latch a cycle late
    step_input_selector u_first_select (
        .i_clk(i_clk),
        .i_reset_n(i_reset_n),
        .i_select(i_first_input_select),
        .i_status_outputs(i_status_output_assignment),
        .i_step_results(i_logic_step_results),
        .i_terminals(sync_terminals),
        .i_forward_run_terminal(sync_forward),
        .i_reverse_run_terminal(sync_reverse),
        .i_final_drive_command(i_final_drive_command),
        .i_final_forward_command(i_final_forward_command),
        .i_final_reverse_command(i_final_reverse_command),
        .i_accelerating_flag(i_accelerating_flag),
        .i_decelerating_flag(i_decelerating_flag),
        .i_anti_regeneration_flag(i_anti_regeneration_flag),
        .i_alarm_factor_flag(i_alarm_factor_flag),
        .o_selected(first_input)
    );

    step_input_selector u_second_select (
        .i_clk(i_clk),
        .i_reset_n(i_reset_n),
        .i_select(i_second_input_select),
        .i_status_outputs(i_status_output_assignment),
        .i_step_results(i_logic_step_results),
        .i_terminals(sync_terminals),
        .i_forward_run_terminal(sync_forward),
        .i_reverse_run_terminal(sync_reverse),
        .i_final_drive_command(i_final_drive_command),
        .i_final_forward_command(i_final_forward_command),
        .i_final_reverse_command(i_final_reverse_command),
        .i_accelerating_flag(i_accelerating_flag),
        .i_decelerating_flag(i_decelerating_flag),
        .i_anti_regeneration_flag(i_anti_regeneration_flag),
        .i_alarm_factor_flag(i_alarm_factor_flag),
        .o_selected(second_input)
    );

    // Period looked up every cycle but only loaded when the count runs out
    always_comb begin
        reload_count = task_period(i_task_cycle_select);
    end

    // Task cycle divider; a period change takes effect at the next reload
    always_comb begin
        next_task_tick = 1'b0;
        next_tick_count = tick_count - 1'b1;
        if (tick_count == '0) begin
            next_task_tick = 1'b1;
            next_tick_count = reload_count;
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            // Count starts at zero, so the first evaluation follows release at once
            tick_count <= '0;
            o_task_tick <= 1'b0;
        end else begin
            tick_count <= next_tick_count;
            o_task_tick <= next_task_tick;
        end
    end

    // One evaluation of the latch; a mode outside the two known codes keeps
    // the stored value rather than guessing a priority
    function automatic logic latch_next(
        input latch_mode_t mode,
        input logic set_in,
        input logic clear_in,
        input logic prev
    );
        logic result;
        result = prev;
        case (mode)
            LATCH_SET_PRIORITY: begin
                if (set_in) begin
                    result = 1'b1;
                end else if (clear_in) begin
                    result = 1'b0;
                end else begin
                    result = prev;
                end
            end
            LATCH_RESET_PRIORITY: begin
                if (clear_in) begin
                    result = 1'b0;
                end else if (set_in) begin
                    result = 1'b1;
                end else begin
                    result = prev;
                end
            end
            default: begin
                result = prev;
            end
        endcase
        return result;
    endfunction : latch_next

    // Latch evaluated only on the task tick; between ticks inputs are ignored
    always_comb begin
        next_result = o_logic_step_result;
        if (next_task_tick) begin
            next_result = latch_next(i_latch_mode, first_input, second_input,
                o_logic_step_result);
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_logic_step_result <= RESULT_RESET;
        end else begin
            o_logic_step_result <= next_result;
        end
    end

endmodule : logic_step_flipflop

// ### logic_step_pkg.sv
package logic_step_pkg;

    // Clock and task cycle timing
    localparam int CLK_FREQ_HZ = 20_000_000;
    localparam int TASK_2MS_US = 2000;
    localparam int TASK_5MS_US = 5000;
    localparam int TASK_10MS_US = 10000;
    localparam int TASK_20MS_US = 20000;
    localparam int TASK_2MS_CYCLES = CLK_FREQ_HZ / 1_000_000 * TASK_2MS_US;
    localparam int TASK_5MS_CYCLES = CLK_FREQ_HZ / 1_000_000 * TASK_5MS_US;
    localparam int TASK_10MS_CYCLES = CLK_FREQ_HZ / 1_000_000 * TASK_10MS_US;
    localparam int TASK_20MS_CYCLES = CLK_FREQ_HZ / 1_000_000 * TASK_20MS_US;
    localparam int TICK_CNT_W = 19;

    // Task cycle choice codes
    localparam logic [1:0] TASK_SEL_2MS = 2'h0;
    localparam logic [1:0] TASK_SEL_5MS = 2'h1;
    localparam logic [1:0] TASK_SEL_10MS = 2'h2;
    localparam logic [1:0] TASK_SEL_20MS = 2'h3;

    // Widths of the select code and of the source groups
    localparam int SELECT_W = 14;
    localparam int STATUS_COUNT = 216;
    localparam int STEP_COUNT = 200;
    localparam int TERMINAL_COUNT = 5;

    // Input select code map
    localparam int CODE_INVERT_OFFSET = 1000;
    localparam int STATUS_LO_END = 99;
    localparam int STATUS_HI_START = 160;
    localparam int STATUS_HI_END = 215;
    localparam int STATUS_UNIVERSAL_DO = 27;
    localparam int STATUS_LOGIC_FIRST = 111;
    localparam int STATUS_LOGIC_LAST = 120;
    localparam int STEP_BASE = 2000;
    localparam int TERMINAL_BASE = 4000;
    localparam int FORWARD_CODE = 4010;
    localparam int REVERSE_CODE = 4011;
    localparam int DRIVE_CMD_CODE = 6000;
    localparam int FORWARD_CMD_CODE = 6001;
    localparam int REVERSE_CMD_CODE = 6002;
    localparam int ACCEL_CODE = 6003;
    localparam int DECEL_CODE = 6004;
    localparam int ANTI_REGEN_CODE = 6005;
    localparam int ALARM_CODE = 6007;
    localparam int INVERTED_GROUP_SPAN = 1000;

    // Values after reset
    localparam logic RESULT_RESET = 1'b0;
    localparam logic SELECTED_RESET = 1'b0;

    typedef enum logic [1:0] {
        LATCH_SET_PRIORITY = 2'b01,
        LATCH_RESET_PRIORITY = 2'b10
    } latch_mode_t;

endpackage : logic_step_pkg

// ### step_input_selector.sv
`timescale 1ns/1ps
module step_input_selector
    import logic_step_pkg::*;
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_reset_n,
    // Select code
    input wire logic [SELECT_W-1:0] i_select,
    // Sources
    input wire logic [STATUS_COUNT-1:0] i_status_outputs,
    input wire logic [STEP_COUNT-1:0] i_step_results,
    input wire logic [TERMINAL_COUNT-1:0] i_terminals,
    input wire logic i_forward_run_terminal,
    input wire logic i_reverse_run_terminal,
    input wire logic i_final_drive_command,
    input wire logic i_final_forward_command,
    input wire logic i_final_reverse_command,
    input wire logic i_accelerating_flag,
    input wire logic i_decelerating_flag,
    input wire logic i_anti_regeneration_flag,
    input wire logic i_alarm_factor_flag,
    // Selected signal
    output logic o_selected
);

    logic next_selected;

    // Unknown or refused codes give OFF, even in their inverted form
    function automatic logic decode(input logic [SELECT_W-1:0] code);
        int c;
        int base;
        logic inv;
        logic val;
        c = int'(code);
        base = c;
        inv = 1'b0;
        val = 1'b0;
        if (c < STEP_BASE) begin
            inv = (c >= CODE_INVERT_OFFSET);
            base = inv ? c - CODE_INVERT_OFFSET : c;
            if (base == STATUS_UNIVERSAL_DO) begin
                val = 1'b0;
                inv = 1'b0;
            end else if (base >= STATUS_LOGIC_FIRST && base <= STATUS_LOGIC_LAST) begin
                val = 1'b0;
                inv = 1'b0;
            end else if (base <= STATUS_LO_END ||
                         (base >= STATUS_HI_START && base <= STATUS_HI_END)) begin
                val = i_status_outputs[base];
            end else begin
                inv = 1'b0;
            end
        end else if (c < TERMINAL_BASE) begin
            inv = (c > STEP_BASE + INVERTED_GROUP_SPAN);
            base = inv ? c - STEP_BASE - INVERTED_GROUP_SPAN : c - STEP_BASE;
            if (base >= 1 && base <= STEP_COUNT) begin
                val = i_step_results[base-1];
            end else begin
                inv = 1'b0;
            end
        end else if (c < DRIVE_CMD_CODE) begin
            inv = (c >= TERMINAL_BASE + INVERTED_GROUP_SPAN);
            base = inv ? c - INVERTED_GROUP_SPAN : c;
            if (base >= TERMINAL_BASE + 1 && base <= TERMINAL_BASE + TERMINAL_COUNT) begin
                val = i_terminals[base-TERMINAL_BASE-1];
            end else if (base == FORWARD_CODE) begin
                val = i_forward_run_terminal;
            end else if (base == REVERSE_CODE) begin
                val = i_reverse_run_terminal;
            end else begin
                inv = 1'b0;
            end
        end else begin
            inv = (c >= DRIVE_CMD_CODE + INVERTED_GROUP_SPAN);
            base = inv ? c - INVERTED_GROUP_SPAN : c;
            case (base)
                DRIVE_CMD_CODE: val = i_final_drive_command;
                FORWARD_CMD_CODE: val = i_final_forward_command;
                REVERSE_CMD_CODE: val = i_final_reverse_command;
                ACCEL_CODE: val = i_accelerating_flag;
                DECEL_CODE: val = i_decelerating_flag;
                ANTI_REGEN_CODE: val = i_anti_regeneration_flag;
                ALARM_CODE: val = i_alarm_factor_flag;
                default: inv = 1'b0;
            endcase
            if (c >= DRIVE_CMD_CODE + 2 * INVERTED_GROUP_SPAN) begin
                inv = 1'b0;
                val = 1'b0;
            end
        end
        return val ^ inv;
    endfunction : decode

    always_comb begin
        next_selected = decode(i_select);
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_selected <= SELECTED_RESET;
        end else begin
            o_selected <= next_selected;
        end
    end

endmodule : step_input_selector

// ### logic_step_flipflop_sva.sv
`timescale 1ns/1ps
module logic_step_checker
    import logic_step_pkg::*;
#(
    parameter int TASK_2MS_COUNT = 4,
    parameter int TASK_5MS_COUNT = 6,
    parameter int TASK_10MS_COUNT = 8,
    parameter int TASK_20MS_COUNT = 10
)(
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire latch_mode_t i_latch_mode,
    input wire logic [SELECT_W-1:0] i_first_input_select,
    input wire logic [SELECT_W-1:0] i_second_input_select,
    input wire logic i_final_drive_command,
    input wire logic i_final_forward_command,
    input wire logic o_logic_step_result,
    input wire logic o_task_tick
);
    int gap, next_gap;
    logic warm, next_warm, sm, rm, cp, bad1;
    assign sm = i_latch_mode == LATCH_SET_PRIORITY;
    assign rm = i_latch_mode == LATCH_RESET_PRIORITY;
    assign cp = i_first_input_select == DRIVE_CMD_CODE && i_second_input_select == FORWARD_CMD_CODE;
    assign bad1 = i_first_input_select inside {14'h001b, 14'h0457, 14'h0460}
        && i_second_input_select == FORWARD_CMD_CODE;
    always_comb begin
        next_gap = o_task_tick ? 0 : gap + 1;
        next_warm = warm | o_task_tick;
    end
    // Warm masks the first tick, which still sees selector state from reset
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            gap <= 0;
            warm <= 1'b0;
        end else begin
            gap <= next_gap;
            warm <= next_warm;
        end
    end
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);
    a_set_wins:
        assert property (o_task_tick && warm && $past(sm) && $past(cp, 2)
            && $past(i_final_drive_command, 2) |-> o_logic_step_result) else $error("set lost");
    a_set_clears:
        assert property (o_task_tick && warm && $past(sm) && $past(cp, 2) && $past(i_final_forward_command, 2)
            && !$past(i_final_drive_command, 2) |-> !o_logic_step_result) else $error("clear lost");
    a_reset_wins:
        assert property (o_task_tick && warm && $past(rm) && $past(cp, 2)
            && $past(i_final_forward_command, 2) |-> !o_logic_step_result) else $error("reset lost");
    a_reset_sets:
        assert property (o_task_tick && warm && $past(rm) && $past(cp, 2) && $past(i_final_drive_command, 2)
            && !$past(i_final_forward_command, 2) |-> o_logic_step_result) else $error("set lost");
    a_both_off_hold:
        assert property (o_task_tick && warm && $past(sm || rm) && $past(cp, 2)
            && !$past(i_final_drive_command, 2) && !$past(i_final_forward_command, 2)
            |-> o_logic_step_result == $past(o_logic_step_result)) else $error("hold lost");
    a_refused_off:
        assert property (o_task_tick && warm && $past(sm) && $past(bad1, 2)
            && $past(i_final_forward_command, 2) |-> !o_logic_step_result) else $error("refused code");
    a_first_tick_off:
        assert property (o_task_tick && !warm |-> !o_logic_step_result) else $error("power-up on");
    a_quiet_between:
        assert property (!o_task_tick |-> $stable(o_logic_step_result)) else $error("off-tick change");
    a_tick_period:
        assert property (o_task_tick && warm |-> gap + 1 inside {TASK_2MS_COUNT, TASK_5MS_COUNT,
            TASK_10MS_COUNT, TASK_20MS_COUNT}) else $error("tick spacing");
    cover property (o_task_tick && warm && $past(sm) && $past(cp, 2));
    cover property (o_task_tick && warm && $past(rm) && $past(cp, 2));
    cover property (o_task_tick && warm && $past(sm) && $past(bad1, 2));
endmodule : logic_step_checker

bind logic_step_flipflop logic_step_checker #(
    .TASK_2MS_COUNT(TASK_2MS_COUNT), .TASK_5MS_COUNT(TASK_5MS_COUNT),
    .TASK_10MS_COUNT(TASK_10MS_COUNT), .TASK_20MS_COUNT(TASK_20MS_COUNT)
) checker_i (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_latch_mode(i_latch_mode),
    .i_first_input_select(i_first_input_select), .i_second_input_select(i_second_input_select),
    .i_final_drive_command(i_final_drive_command), .i_final_forward_command(i_final_forward_command),
    .o_logic_step_result(o_logic_step_result), .o_task_tick(o_task_tick));

// ### test_logic_step_flipflop.sv
`timescale 1ns/1ps
module test_logic_step_flipflop;
    import logic_step_pkg::*;
    localparam int CNT [4] = '{8, 10, 12, 14};
    logic i_clk = 1'b0;
    logic i_reset_n = 1'b0;
    logic [1:0] task_sel = 2'h0;
    latch_mode_t mode = LATCH_SET_PRIORITY;
    logic [SELECT_W-1:0] sel1 = '0;
    logic [SELECT_W-1:0] sel2 = '0;
    logic [STATUS_COUNT-1:0] st = '0;
    logic [STEP_COUNT-1:0] sr = '0;
    logic [TERMINAL_COUNT-1:0] term = '0;
    logic [5:0] cmd = '0;
    logic forward_run_terminal = 1'b0, reverse_run_terminal = 1'b0, alarm = 1'b0, q = 1'b0;
    logic result, tick;
    logic res_q[$];
    int gap_q[$];
    int miscompares = 0, num_checks = 0, cyc = 0, gap = 0;

    logic_step_flipflop #(.TASK_2MS_COUNT(CNT[0]), .TASK_5MS_COUNT(CNT[1]),
        .TASK_10MS_COUNT(CNT[2]), .TASK_20MS_COUNT(CNT[3])) dut (
        .i_clk(i_clk), .i_reset_n(i_reset_n), .i_task_cycle_select(task_sel),
        .i_latch_mode(mode), .i_first_input_select(sel1), .i_second_input_select(sel2),
        .i_status_output_assignment(st), .i_logic_step_results(sr),
        .i_final_drive_command(cmd[0]), .i_final_forward_command(cmd[1]),
        .i_final_reverse_command(cmd[2]), .i_accelerating_flag(cmd[3]),
        .i_decelerating_flag(cmd[4]), .i_anti_regeneration_flag(cmd[5]),
        .i_alarm_factor_flag(alarm), .i_digital_terminals(term),
        .i_forward_run_terminal(forward_run_terminal), .i_reverse_run_terminal(reverse_run_terminal),
        .o_logic_step_result(result), .o_task_tick(tick));

    initial forever #25 i_clk = ~i_clk;

    function automatic logic pick(input int c);
        bit inv;
        int b;
        inv = (c / 1000) % 2 == 1;
        b = inv ? c - 1000 : c;
        if ((b <= 99 || (b >= 160 && b <= 215)) && b != 27) return st[b] ^ inv;
        if (b >= 2001 && b <= 2200) return sr[b-2001] ^ inv;
        if (b >= 4001 && b <= 4005) return term[b-4001] ^ inv;
        if (b == 4010 || b == 4011) return (b == 4010 ? forward_run_terminal : reverse_run_terminal) ^ inv;
        if (b >= 6000 && b <= 6005) return cmd[b-6000] ^ inv;
        if (b == 6007) return alarm ^ inv;
        return 1'b0;
    endfunction : pick

    task automatic print_verdict();
        $display("Checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : print_verdict

    task automatic check_bit(input logic got, input logic exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %0t result %b expected %b", $time, got, exp);
        end
    endtask : check_bit

    task automatic check_gap(input int got, input int exp);
        num_checks++;
        if (got != exp) begin
            miscompares++;
            $display("BAD %0t tick gap %0d expected %0d", $time, got, exp);
        end
    endtask : check_gap

    // Inputs change just after a tick, so the next evaluation sees them settled
    task automatic step(input int c1, input int c2, input latch_mode_t m, input bit f, input int g);
        int n;
        n = 0;
        do begin
            @(posedge i_clk);
            #5;
            n++;
        end while (tick !== 1'b1 && n < 40);
        foreach (st[i]) st[i] = 1'($urandom_range(1));
        foreach (sr[i]) sr[i] = 1'($urandom_range(1));
        cmd = 6'($urandom) | {4'h0, f, 1'b0};
        term = 5'($urandom);
        forward_run_terminal = 1'($urandom);
        reverse_run_terminal = 1'($urandom);
        alarm = 1'($urandom);
        sel1 = SELECT_W'(c1);
        sel2 = SELECT_W'(c2);
        mode = m;
        if (m == LATCH_SET_PRIORITY) q = pick(c1) | (!pick(c2) & q);
        else if (m == LATCH_RESET_PRIORITY) q = !pick(c2) & (pick(c1) | q);
        res_q.push_back(q);
        if (g > 0) gap_q.push_back(g);
    endtask : step

    always @(posedge i_clk) begin
        #1;
        cyc++;
        gap++;
        if (cyc > 5000) begin
            miscompares++;
            print_verdict();
        end else if (i_reset_n && tick === 1'b1) begin
            if (res_q.size() > 0) check_bit(result, res_q.pop_front());
            if (gap_q.size() > 0) check_gap(gap, gap_q.pop_front());
            gap = 0;
        end
    end

    initial begin
        int codes[$] = '{0, 27, 99, 100, 111, 120, 160, 215, 216, 1000, 1027, 1099, 1111, 1120,
            1160, 1215, 2000, 2001, 2200, 2201, 3001, 3200, 4001, 4005, 4006, 4010, 4011, 5001,
            5005, 5010, 5011, 6000, 6001, 6002, 6003, 6004, 6005, 6006, 6007, 7000, 7005, 7007, 7008};
        void'($urandom(42));
        res_q.push_back(1'b0);
        repeat (3) @(posedge i_clk);
        #5;
        i_reset_n = 1'b1;
        repeat (24) step(6000, 6001, LATCH_SET_PRIORITY, 0, 0);
        repeat (24) step(6000, 6001, LATCH_RESET_PRIORITY, 0, 0);
        repeat (2) step(6000, 6001, latch_mode_t'(2'h0), 0, 0);
        // Second input pinned ON so set mode shows the first input directly
        foreach (codes[i]) repeat (2) step(codes[i], 6001, LATCH_SET_PRIORITY, 1, 0);
        repeat (40) step(int'($urandom_range(7999)), int'($urandom_range(7999)),
            latch_mode_t'(2'($urandom_range(1, 2))), 0, 0);
        for (int s = 3; s >= 0; s--) begin
            step(6000, 6001, LATCH_SET_PRIORITY, 0, 0);
            task_sel = 2'(s);
            step(6000, 6001, LATCH_SET_PRIORITY, 0, 0);
            step(6000, 6001, LATCH_SET_PRIORITY, 0, CNT[s]);
        end
        repeat (20) @(posedge i_clk);
        // Expectations left over mean evaluations stopped coming
        if (res_q.size() + gap_q.size() != 0) begin
            miscompares++;
            $display("BAD %0t %0d expectations never checked", $time, res_q.size() + gap_q.size());
        end
        print_verdict();
    end
endmodule : test_logic_step_flipflop
